/* core/sram_sleep_mode_control.sv */
// Sleep entry, hold and recovery control for a synchronous burst SRAM
// Notes on behaviour
// - Sleep entered two clock cycles after request; the two-stage synchroniser adds two more cycles on top
// - Stored contents and state kept through sleep
// - Asleep: deselected, inputs ignored, outputs high-Z
// - Async active-high request; sleep while high
// - Resume after recovery of at least 20 ns
// - Undriven request reads low, normal operation
`timescale 1ns/100ps
module sram_sleep_mode_control
(
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_sleep_request,
   input  wire logic i_sleep_request_driven,
   input  wire logic i_chip_select,
   input  wire logic i_write_cmd,
   input  wire logic i_out_enable_n,
   output logic      o_asleep,
   output logic      o_recovering,
   output logic      o_select_eff,
   output logic      o_write_eff,
   output logic      o_write_blocked,
   output logic      o_dq_oe_n,
   output logic      o_clock_gate_en
);
   sleep_ctrl_pkg::sleep_state_e state_q;
   sleep_ctrl_pkg::sleep_state_e state_d;
   logic [2:0]                   cnt_q;
   logic [2:0]                   cnt_d;
   logic                         req_pin;
   logic                         req_sync;
   logic                         asleep_q;
   logic                         asleep_d;
   logic                         rec_q;
   logic                         rec_d;
   logic                         gate_q;
   logic                         gate_d;

   // Write attempt as seen on the pins; both write outputs decode it
   function automatic logic write_attempt
   (
      input logic wr,
      input logic cs
   );
      write_attempt = wr & cs;
   endfunction

   // End of either countdown
   function automatic logic count_expired
   (
      input logic [2:0] cnt
   );
      count_expired = (cnt == sleep_ctrl_pkg::CNT_RESET);
   endfunction

   // Entry countdown load; synchroniser delay comes on top of it
   function automatic logic [2:0] entry_load();
      entry_load = 3'(sleep_ctrl_pkg::SLEEP_ENTRY_CYCLES - 1);
   endfunction

   // Recovery countdown load, already rounded up to whole cycles
   function automatic logic [2:0] recovery_load();
      recovery_load = 3'(sleep_ctrl_pkg::RECOVERY_CYCLES - 1);
   endfunction

   // Pull-down model: floating pin counts as low
   assign req_pin = i_sleep_request_driven & i_sleep_request;

   sleep_req_sync u_sync
   (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  (req_pin),
      .o_sync   (req_sync)
   );

   // Entry count starts from the first edge that sees the synchronised
   // request; synchroniser latency is added on top of the two cycles.
   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      asleep_d = asleep_q;
      rec_d    = rec_q;
      case (state_q)
         sleep_ctrl_pkg::ST_AWAKE:
         begin
            if (req_sync)
            begin
               state_d = sleep_ctrl_pkg::ST_ENTERING;
               cnt_d   = entry_load();
            end
         end
         sleep_ctrl_pkg::ST_ENTERING:
         begin
            if (!req_sync)
            begin
               state_d = sleep_ctrl_pkg::ST_AWAKE;
               cnt_d   = sleep_ctrl_pkg::CNT_RESET;
            end
            else if (count_expired(cnt_q))
            begin
               state_d  = sleep_ctrl_pkg::ST_ASLEEP;
               asleep_d = 1'b1;
            end
            else
            begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         sleep_ctrl_pkg::ST_ASLEEP:
         begin
            if (!req_sync)
            begin
               state_d  = sleep_ctrl_pkg::ST_RECOVER;
               asleep_d = 1'b0;
               rec_d    = 1'b1;
               cnt_d    = recovery_load();
            end
         end
         sleep_ctrl_pkg::ST_RECOVER:
         begin
            if (req_sync)
            begin
               state_d  = sleep_ctrl_pkg::ST_ENTERING;
               rec_d    = 1'b0;
               cnt_d    = entry_load();
            end
            else if (count_expired(cnt_q))
            begin
               state_d = sleep_ctrl_pkg::ST_AWAKE;
               rec_d   = 1'b0;
            end
            else
            begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         default:
         begin
            state_d  = sleep_ctrl_pkg::ST_AWAKE;
            cnt_d    = sleep_ctrl_pkg::CNT_RESET;
            asleep_d = 1'b0;
            rec_d    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_q  <= sleep_ctrl_pkg::ST_AWAKE;
         cnt_q    <= sleep_ctrl_pkg::CNT_RESET;
         asleep_q <= 1'b0;
         rec_q    <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         asleep_q <= asleep_d;
         rec_q    <= rec_d;
      end
   end

   // Access clock enable in its own flop; tracks the sleep flag exactly
   always_comb
   begin
      gate_d = ~asleep_d;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         gate_q <= 1'b1;
      end
      else
      begin
         gate_q <= gate_d;
      end
   end

   assign o_asleep        = asleep_q;
   assign o_recovering    = rec_q;
   // Only the access path is gated; array contents are never touched here
   assign o_clock_gate_en = gate_q;
   assign o_select_eff    = i_chip_select & ~asleep_q;
   // Writes during recovery are the controller's fault; dropped defensively
   assign o_write_eff     = write_attempt(i_write_cmd, i_chip_select) & ~asleep_q & ~rec_q;
   assign o_write_blocked = write_attempt(i_write_cmd, i_chip_select) & rec_q;
   assign o_dq_oe_n       = asleep_q | i_out_enable_n;
endmodule

/* common/sleep_ctrl_pkg.sv */
// Constants for the SRAM sleep-mode controller
package sleep_ctrl_pkg;
   localparam int unsigned CLK_PERIOD_PS          = 40000;
   localparam int unsigned SLEEP_ENTRY_CYCLES     = 2;
   localparam int unsigned RECOVERY_TIME_NS       = 20;
   // Least time: round up, at least one cycle
   localparam int unsigned RECOVERY_CYCLES_RAW    = (RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RECOVERY_CYCLES        = (RECOVERY_CYCLES_RAW < 1) ? 1 : RECOVERY_CYCLES_RAW;
   localparam int unsigned CNT_W                  = 3;
   localparam logic [2:0]  CNT_RESET              = 3'h0;
   localparam logic        REQ_RESET              = 1'b0;

   typedef enum logic [1:0] {
      ST_AWAKE,
      ST_ENTERING,
      ST_ASLEEP,
      ST_RECOVER
   } sleep_state_e;
endpackage

/* core/sleep_req_sync.sv */
// Two-stage synchroniser for the sleep request pin
`timescale 1ns/100ps
module sleep_req_sync
(
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb
   begin
      meta_d = i_async;
      sync_d = meta_q;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         meta_q <= sleep_ctrl_pkg::REQ_RESET;
         sync_q <= sleep_ctrl_pkg::REQ_RESET;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q;
endmodule

/* verif/sleep_ctrl_sva.sv */
// Port assertions for the sleep controller
`timescale 1ns/100ps
module sleep_ctrl_sva (
   input wire logic i_clk, i_resetn, i_sleep_request, i_sleep_request_driven, i_chip_select,
   input wire logic i_write_cmd, i_out_enable_n, o_asleep, o_recovering, o_select_eff,
   input wire logic o_write_eff, o_write_blocked, o_dq_oe_n, o_clock_gate_en
);
   // Floating pin reads low
   wire logic req = i_sleep_request & i_sleep_request_driven;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   entry_delay_a: assert property ($rose(o_asleep) |-> $past(req, 5))
      else $error("sleep entry timing");
   exit_delay_a: assert property ($fell(o_asleep) |-> !$past(req, 3) && o_recovering)
      else $error("wake timing");
   recover_one_a: assert property (o_recovering |=> !o_recovering)
      else $error("recovery length");
   asleep_hiz_a: assert property (o_asleep |-> o_dq_oe_n && !o_select_eff && !o_write_eff)
      else $error("asleep outputs");
   stay_asleep_a: assert property (req [*4] ##0 o_asleep |=> o_asleep)
      else $error("left sleep early");
   recov_write_a: assert property (o_recovering && i_write_cmd && i_chip_select |-> o_write_blocked && !o_write_eff)
      else $error("write in recovery");
   float_low_a: assert property (!i_sleep_request_driven [*5] |=> !o_asleep)
      else $error("floating pin slept");
   awake_pass_a: assert property (!o_asleep |-> o_select_eff == i_chip_select && o_clock_gate_en)
      else $error("awake gating");
   cover property ($rose(o_asleep));
   cover property (o_write_blocked);
   cover property ($fell(o_recovering));
endmodule

/* verif/sram_host_model.sv */
// Host controller model driving sleep request and write command
`timescale 1ns/100ps
module sram_host_model (
   input  wire logic i_clk,
   input  wire logic i_sleep,
   input  wire logic i_wr,
   input  wire logic i_rude,
   output logic      o_sleep_request = 1'b0,
   output logic      o_write_cmd = 1'b0
);
   logic [2:0] quiet_q = 3'h0;
   // Launch on the falling edge, clear of the sampling edge
   always @(negedge i_clk)
   begin
      o_sleep_request <= i_sleep && (o_sleep_request || !o_write_cmd);
      quiet_q <= o_sleep_request ? 3'h6 : quiet_q - {2'h0, |quiet_q};
      o_write_cmd <= i_wr && (i_rude || (!i_sleep && quiet_q == 3'h0));
   end
endmodule

/* verif/tb_sram_sleep_mode_control.sv */
// Self-checking bench for the sleep controller
`timescale 1ns/100ps
module tb_sram_sleep_mode_control;
   logic i_clk = 1'b0, i_resetn = 1'b0, i_sleep_request_driven = 1'b1, i_chip_select = 1'b1;
   logic i_out_enable_n = 1'b0, sleep = 1'b0, wr = 1'b0, rude = 1'b0, i_sleep_request, i_write_cmd;
   logic o_asleep, o_recovering, o_select_eff, o_write_eff, o_write_blocked, o_dq_oe_n, o_clock_gate_en;
   int err_total = 0, check_count = 0, cycles = 0;
   sram_host_model i_sram_host_model (.i_clk, .i_sleep(sleep), .i_wr(wr), .i_rude(rude),
      .o_sleep_request(i_sleep_request), .o_write_cmd(i_write_cmd));
   sram_sleep_mode_control i_sram_sleep_mode_control (.*);
   initial forever #20 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_total++;
         test_done();
      end
   end
   task cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task chk(input string name, input logic seen, input logic exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task t_entry();
      sleep <= 1'b1;
      cyc(5);
      chk("asleep", o_asleep, 1'b0);
      cyc(1);
      chk("asleep", o_asleep, 1'b1);
      rude <= 1'b1;
      wr <= 1'b1;
      cyc(20);
      chk("asleep", o_asleep, 1'b1);
      chk("dq_oe_n", o_dq_oe_n, 1'b1);
      chk("select", o_select_eff, 1'b0);
      chk("write", o_write_eff, 1'b0);
      chk("gate", o_clock_gate_en, 1'b0);
      $display("entry test done");
   endtask
   task t_exit();
      sleep <= 1'b0;
      cyc(3);
      chk("asleep", o_asleep, 1'b1);
      cyc(1);
      chk("recover", o_recovering, 1'b1);
      chk("blocked", o_write_blocked, 1'b1);
      chk("write", o_write_eff, 1'b0);
      cyc(1);
      chk("recover", o_recovering, 1'b0);
      chk("write", o_write_eff, 1'b1);
      wr <= 1'b0;
      rude <= 1'b0;
      $display("exit test done");
   endtask
   task t_float();
      i_sleep_request_driven <= 1'b0;
      sleep <= 1'b1;
      cyc(10);
      chk("asleep", o_asleep, 1'b0);
      chk("gate", o_clock_gate_en, 1'b1);
      chk("select", o_select_eff, 1'b1);
      chk("dq_oe_n", o_dq_oe_n, 1'b0);
      i_out_enable_n <= 1'b1;
      cyc(1);
      chk("dq_oe_n", o_dq_oe_n, 1'b1);
      i_out_enable_n <= 1'b0;
      sleep <= 1'b0;
      cyc(2);
      i_sleep_request_driven <= 1'b1;
      cyc(2);
      $display("float test done");
   endtask
   // Request dropped while the entry count runs: no sleep
   task t_abort();
      sleep <= 1'b1;
      cyc(2);
      sleep <= 1'b0;
      cyc(4);
      chk("asleep", o_asleep, 1'b0);
      chk("recover", o_recovering, 1'b0);
      cyc(4);
      chk("asleep", o_asleep, 1'b0);
      $display("abort test done");
   endtask
   // Request raised again inside the recovery cycle
   task t_reenter();
      sleep <= 1'b1;
      cyc(6);
      chk("asleep", o_asleep, 1'b1);
      sleep <= 1'b0;
      cyc(1);
      sleep <= 1'b1;
      cyc(3);
      chk("recover", o_recovering, 1'b1);
      cyc(2);
      chk("asleep", o_asleep, 1'b0);
      cyc(1);
      chk("asleep", o_asleep, 1'b1);
      sleep <= 1'b0;
      cyc(8);
      chk("asleep", o_asleep, 1'b0);
      chk("recover", o_recovering, 1'b0);
      $display("reenter test done");
   endtask
   initial
   begin
      cyc(10);
      i_resetn <= 1'b1;
      cyc(2);
      t_entry();
      t_exit();
      t_float();
      t_abort();
      t_reenter();
      test_done();
   end
endmodule
bind sram_sleep_mode_control sleep_ctrl_sva i_sleep_ctrl_sva (.*);
